// ==== verilog/lscd_pkg.sv ====
// Package: addresses, field positions, reset values and level codes for the LCD driver
package lscd_pkg;
  // Register and memory map
  localparam logic [15:0] MODE_ADDR     = 16'hFFB0;
  localparam logic [15:0] CLK_ADDR      = 16'hFFB2;
  localparam logic [15:0] MEM_BASE      = 16'hFA00;
  localparam logic [15:0] MEM_LAST      = 16'hFA1B;
  localparam int          MEM_BYTES     = 28;
  localparam int          SEG_FIXED     = 16;
  localparam int          SEG_OPTIONAL  = 12;
  // Reset values
  localparam logic [7:0]  MODE_RESET    = 8'h00;
  localparam logic [7:0]  CLK_RESET     = 8'h00;
  // Display mode fields
  localparam int          DISPLAY_ENABLE_POS = 7;
  localparam int          PIN_OUTPUT_POS     = 4;
  localparam int          SLICE_SELECT_POS   = 0;
  localparam logic [7:0]  MODE_MASK          = 8'h91;
  // Clock control fields
  localparam int          SRC_SEL_LSB   = 2;
  localparam int          DIV_SEL_LSB   = 0;
  localparam logic [7:0]  CLK_MASK      = 8'h0F;
  // Divider exponents: main clock / 2^(5+code-1), panel clock / 2^(6+code)
  localparam int          SRC_EXP_BASE  = 4;
  localparam int          DIV_EXP_BASE  = 6;
  localparam int          PRESCALE_W    = 7;
  localparam int          PANEL_DIV_W   = 9;
  // Level codes for a 1/3-bias selector: 0 = ground .. 3 = full drive
  localparam logic [1:0]  LVL_0 = 2'h0;
  localparam logic [1:0]  LVL_1 = 2'h1;
  localparam logic [1:0]  LVL_2 = 2'h2;
  localparam logic [1:0]  LVL_3 = 2'h3;
  // Common slot, Gray coded along the scan
  typedef enum logic [1:0] {
    SLOT0 = 2'h0,
    SLOT1 = 2'h1,
    SLOT2 = 2'h3,
    SLOT3 = 2'h2
  } lscd_slot_t;
endpackage

// ==== verilog/lscd_clk_if.sv ====
// Interface: clock settings to the divider and panel clock enable back
`timescale 1ns/1ns
interface lscd_clk_if;
  logic       run;
  logic [1:0] src_sel;
  logic [1:0] div_sel;
  logic       panel_tick;
  modport ctrl (output run, output src_sel, output div_sel, input panel_tick);
  modport div  (input run, input src_sel, input div_sel, output panel_tick);
endinterface

// ==== verilog/lscd_clk_div.sv ====
// Divider: source clock select and panel clock enable generation
`timescale 1ns/1ns
module lscd_clk_div (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Subsystem clock, one-cycle pulse per subsystem period
  input  wire logic sub_clk_tick,
  // Settings and enable
  lscd_clk_if.div   cif
);
  logic [lscd_pkg::PRESCALE_W-1:0]  prescale;
  logic [lscd_pkg::PANEL_DIV_W-1:0] panel_cnt;
  logic                             src_tick;

  // Terminal count of 2^exp - 1, used by both stages
  function automatic logic [8:0] last_count(input int unsigned exp_val);
    last_count = 9'((1 << exp_val) - 1);
  endfunction

  // Main clock prescaler, free running while the pins are driven
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prescale <= '0;
    end else if (!cif.run) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 7'h01;
    end
  end

  always_comb begin
    if (cif.src_sel == 2'h0) begin
      src_tick = sub_clk_tick;
    end else begin
      src_tick = ({2'h0, prescale} & last_count(lscd_pkg::SRC_EXP_BASE + 32'(cif.src_sel)))
                 == last_count(lscd_pkg::SRC_EXP_BASE + 32'(cif.src_sel));
    end
  end

  // Panel clock as an enable; no derived clock net reaches the flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      panel_cnt <= '0;
    end else if (!cif.run) begin
      panel_cnt <= '0;
    end else if (src_tick) begin
      if (panel_cnt >= last_count(lscd_pkg::DIV_EXP_BASE + 32'(cif.div_sel))) begin
        panel_cnt <= '0;
      end else begin
        panel_cnt <= panel_cnt + 9'h001;
      end
    end
  end

  assign cif.panel_tick = cif.run && src_tick
    && (panel_cnt >= last_count(lscd_pkg::DIV_EXP_BASE + 32'(cif.div_sel)));

  tick_gap_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    cif.panel_tick |=> !cif.panel_tick [*8])
    else $error("panel clock enable pulses closer than the minimum division");
endmodule

// ==== verilog/lscd_top.sv ====
// Segment LCD controller: registers, display memory and multiplexed level outputs
// How it works
// - Four commons and 16 to 28 segments, one segment per memory byte.
// - Display memory at FA00H..FA1BH; upper four bits always read zero.
// - Each of the upper twelve segments may be a port pin instead.
// - Mode register at FFB0H, read/write, resets to 00H.
// - Display enable low, with pin output on, forces every segment to the deselect level.
// - Pin output control low grounds all segment and common pins.
// - Mode bit 0 picks four slices (0) or three slices (1).
// - Clock control register at FFB2H, read/write, resets to 00H.
// - Clock bits 3:2 pick subsystem clock or main clock /32, /64, /128.
// - Clock bits 1:0 divide the source by 64, 128, 256 or 512.
// - Frame rate is the panel clock divided by the slice count.
// - Both control registers take single-bit and full-byte writes.
// - Segment shows memory bit n during common slot n; 1 selects.
// - Commons are selected in turn, one per slice, continuously.
// - In three-slice mode bit 3 is ignored and the fourth common idles.
`timescale 1ns/1ns
module lscd_top #(
  parameter int NUM_SEG = 28
) (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      arst_n,
  // Subsystem clock, one-cycle pulse per period
  input  wire logic                      sub_clk_tick,
  // Internal memory bus
  input  wire logic [15:0]               bus_addr,
  input  wire logic                      bus_wr,
  input  wire logic [7:0]                bus_wdata,
  input  wire logic                      bus_bit_wr,
  input  wire logic [2:0]                bus_bit_idx,
  input  wire logic                      bus_bit_val,
  input  wire logic                      bus_rd,
  output logic      [7:0]                bus_rdata,
  // Port function selection for the optional segments, 1 = port pin
  input  wire logic [lscd_pkg::SEG_OPTIONAL-1:0] seg_port_sel,
  // Panel drive level codes
  output logic      [NUM_SEG-1:0][1:0]   seg_level,
  output logic      [NUM_SEG-1:0]        seg_drive_en,
  output logic      [3:0][1:0]           com_level
);
  logic [7:0]              display_mode_ctrl;
  logic [7:0]              display_clock_ctrl;
  logic [3:0]              disp_mem [lscd_pkg::MEM_BYTES];
  lscd_pkg::lscd_slot_t    slot;
  logic                    polarity;
  logic                    display_enable_bit;
  logic                    pin_output_ctrl_bit;
  logic                    slice_count_select;
  logic                    frame_end;
  logic [7:0]              next_mode;
  logic [7:0]              next_clk;
  logic [7:0]              next_mem;
  logic [4:0]              mem_idx;
  logic                    mem_hit;
  logic [NUM_SEG-1:0][1:0] next_seg;
  logic [3:0][1:0]         next_com;

  lscd_clk_if cif ();

  // Byte write wins over bit write when both arrive together
  function automatic logic [7:0] merge_write(input logic [7:0] old_val);
    merge_write = old_val;
    if (bus_wr) begin
      merge_write = bus_wdata;
    end else if (bus_bit_wr) begin
      merge_write[bus_bit_idx] = bus_bit_val;
    end
  endfunction

  function automatic lscd_pkg::lscd_slot_t next_slot(input lscd_pkg::lscd_slot_t s,
                                                     input logic three);
    unique case (s)
      lscd_pkg::SLOT0: next_slot = lscd_pkg::SLOT1;
      lscd_pkg::SLOT1: next_slot = lscd_pkg::SLOT2;
      lscd_pkg::SLOT2: next_slot = three ? lscd_pkg::SLOT0 : lscd_pkg::SLOT3;
      lscd_pkg::SLOT3: next_slot = lscd_pkg::SLOT0;
    endcase
  endfunction

  function automatic logic [1:0] slot_index(input lscd_pkg::lscd_slot_t s);
    unique case (s)
      lscd_pkg::SLOT0: slot_index = 2'h0;
      lscd_pkg::SLOT1: slot_index = 2'h1;
      lscd_pkg::SLOT2: slot_index = 2'h2;
      lscd_pkg::SLOT3: slot_index = 2'h3;
    endcase
  endfunction

  // Segment select sits at the far rail from the selected common
  function automatic logic [1:0] seg_code(input logic on, input logic pol);
    if (on) begin
      seg_code = pol ? lscd_pkg::LVL_3 : lscd_pkg::LVL_0;
    end else begin
      seg_code = pol ? lscd_pkg::LVL_1 : lscd_pkg::LVL_2;
    end
  endfunction

  function automatic logic [1:0] com_code(input logic sel, input logic pol);
    if (sel) begin
      com_code = pol ? lscd_pkg::LVL_0 : lscd_pkg::LVL_3;
    end else begin
      com_code = pol ? lscd_pkg::LVL_2 : lscd_pkg::LVL_1;
    end
  endfunction

  assign display_enable_bit  = display_mode_ctrl[lscd_pkg::DISPLAY_ENABLE_POS];
  assign pin_output_ctrl_bit = display_mode_ctrl[lscd_pkg::PIN_OUTPUT_POS];
  assign slice_count_select  = display_mode_ctrl[lscd_pkg::SLICE_SELECT_POS];
  assign mem_hit = (bus_addr >= lscd_pkg::MEM_BASE) && (bus_addr <= lscd_pkg::MEM_LAST);
  assign mem_idx = 5'(bus_addr - lscd_pkg::MEM_BASE);

  assign cif.run     = pin_output_ctrl_bit;
  assign cif.src_sel = display_clock_ctrl[lscd_pkg::SRC_SEL_LSB +: 2];
  assign cif.div_sel = display_clock_ctrl[lscd_pkg::DIV_SEL_LSB +: 2];

  lscd_clk_div u_div (
    .core_clk     (core_clk),
    .arst_n       (arst_n),
    .sub_clk_tick (sub_clk_tick),
    .cif          (cif.div)
  );

  // Reserved bits are not stored, so they read as zero whatever is written
  // A process, not an assign: the merge reads the strobes outside its arguments
  always_comb begin
    next_mode = merge_write(display_mode_ctrl) & lscd_pkg::MODE_MASK;
    next_clk  = merge_write(display_clock_ctrl) & lscd_pkg::CLK_MASK;
    next_mem  = merge_write({4'h0, disp_mem[mem_idx]});
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      display_mode_ctrl <= lscd_pkg::MODE_RESET;
    end else if ((bus_wr || bus_bit_wr) && bus_addr == lscd_pkg::MODE_ADDR) begin
      display_mode_ctrl <= next_mode;
    end
  end

  // Clock changes are taken as written; software stops the display first
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      display_clock_ctrl <= lscd_pkg::CLK_RESET;
    end else if ((bus_wr || bus_bit_wr) && bus_addr == lscd_pkg::CLK_ADDR) begin
      display_clock_ctrl <= next_clk;
    end
  end

  // Only the low nibble exists; the upper bits have no storage
  always_ff @(posedge core_clk) begin
    if ((bus_wr || bus_bit_wr) && mem_hit) begin
      disp_mem[mem_idx] <= next_mem[3:0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      if (bus_addr == lscd_pkg::MODE_ADDR) begin
        bus_rdata <= display_mode_ctrl;
      end else if (bus_addr == lscd_pkg::CLK_ADDR) begin
        bus_rdata <= display_clock_ctrl;
      end else if (mem_hit) begin
        bus_rdata <= {4'h0, disp_mem[mem_idx]};
      end else begin
        bus_rdata <= 8'h00;
      end
    end
  end

  // Scan position and frame polarity
  assign frame_end = cif.panel_tick && (next_slot(slot, slice_count_select) == lscd_pkg::SLOT0);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      slot <= lscd_pkg::SLOT0;
    end else if (!pin_output_ctrl_bit) begin
      slot <= lscd_pkg::SLOT0;
    end else if (cif.panel_tick) begin
      slot <= next_slot(slot, slice_count_select);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      polarity <= 1'b0;
    end else if (!pin_output_ctrl_bit) begin
      polarity <= 1'b0;
    end else if (frame_end) begin
      polarity <= ~polarity;
    end
  end

  always_comb begin
    for (int s = 0; s < NUM_SEG; s++) begin
      if (!pin_output_ctrl_bit) begin
        next_seg[s] = lscd_pkg::LVL_0;
      end else if (!display_enable_bit) begin
        next_seg[s] = seg_code(1'b0, polarity);
      end else begin
        next_seg[s] = seg_code(disp_mem[s][slot_index(slot)], polarity);
      end
    end
    for (int c = 0; c < 4; c++) begin
      if (!pin_output_ctrl_bit) begin
        next_com[c] = lscd_pkg::LVL_0;
      end else begin
        next_com[c] = com_code(slot_index(slot) == 2'(c), polarity);
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      seg_level <= '0;
      com_level <= '0;
    end else begin
      seg_level <= next_seg;
      com_level <= next_com;
    end
  end

  // Fixed segments always drive; optional ones follow the port selection
  always_comb begin
    for (int s = 0; s < NUM_SEG; s++) begin
      if (s < lscd_pkg::SEG_FIXED) begin
        seg_drive_en[s] = 1'b1;
      end else begin
        seg_drive_en[s] = !seg_port_sel[s - lscd_pkg::SEG_FIXED];
      end
    end
  end

  sequence mode_write_s;
    bus_wr && bus_addr == lscd_pkg::MODE_ADDR;
  endsequence

  sequence clk_write_s;
    bus_wr && bus_addr == lscd_pkg::CLK_ADDR;
  endsequence

  mode_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    mode_write_s |=> display_mode_ctrl == ($past(bus_wdata) & lscd_pkg::MODE_MASK))
    else $error("mode register did not take the written value");

  clk_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    clk_write_s |=> display_clock_ctrl == ($past(bus_wdata) & lscd_pkg::CLK_MASK))
    else $error("clock control register did not take the written value");

  mem_upper_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (bus_rd && mem_hit) |=> bus_rdata[7:4] == 4'h0)
    else $error("display memory upper bits read nonzero");

  pins_ground_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !pin_output_ctrl_bit |=> seg_level == '0 && com_level == '0)
    else $error("pins not grounded with pin output off");

  seg_deselect_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (pin_output_ctrl_bit && !display_enable_bit)
      |=> seg_level[0] == ($past(polarity) ? 2'h1 : 2'h2))
    else $error("segment not at deselect level with display off");

  seg_follow_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (pin_output_ctrl_bit && display_enable_bit && disp_mem[0][slot_index(slot)])
      |=> seg_level[0] == ($past(polarity) ? 2'h3 : 2'h0))
    else $error("segment did not show select for a set memory bit");

  sequence three_wrap_s;
    pin_output_ctrl_bit && slice_count_select && slot == lscd_pkg::SLOT2 && cif.panel_tick;
  endsequence

  three_wrap_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    three_wrap_s |=> slot == lscd_pkg::SLOT0 && polarity != $past(polarity))
    else $error("three-slice scan did not wrap with polarity flip");

  slot_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (pin_output_ctrl_bit && !cif.panel_tick) |=> $stable(slot))
    else $error("slot moved without a panel clock enable");

  com_select_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    (pin_output_ctrl_bit && slot == lscd_pkg::SLOT1 && !cif.panel_tick)
      |=> com_level[1] == ($past(polarity) ? 2'h0 : 2'h3))
    else $error("active common not at the selected level");
endmodule

// ==== testbench/lscd_panel_model.sv ====
// Passive segment glass model: a pixel lights when segment and common differ by full drive
`timescale 1ns/1ns
module lscd_panel_model #(
  parameter int NUM_SEG = 28
) (
  // Drive levels from the controller
  input  wire logic [NUM_SEG-1:0][1:0] seg_level,
  input  wire logic [3:0][1:0]         com_level,
  // Pixel state, one bit per segment and common
  output logic      [NUM_SEG-1:0][3:0] lit
);
  // Only a full three-step difference lights a pixel; the two third-steps stay dark
  always_comb begin
    int d;
    d = 0;
    for (int s = 0; s < NUM_SEG; s++) begin
      for (int c = 0; c < 4; c++) begin
        d = int'(seg_level[s]) - int'(com_level[c]);
        lit[s][c] = (d == 3) || (d == -3);
      end
    end
  end
endmodule

// ==== testbench/tb_lcd_segment_common_driver.sv ====
// Testbench: registers, display memory and scan levels checked against a behavioural model
`timescale 1ns/1ns
module tb_lcd_segment_common_driver;
  logic                 core_clk, arst_n, sub_clk_tick;
  logic                 bus_wr, bus_bit_wr, bus_bit_val, bus_rd;
  logic [15:0]          bus_addr;
  logic [7:0]           bus_wdata, bus_rdata;
  logic [2:0]           bus_bit_idx;
  logic [11:0]          seg_port_sel;
  logic [27:0][1:0]     seg_level;
  logic [27:0]          seg_drive_en;
  logic [3:0][1:0]      com_level;
  logic [27:0][3:0]     lit;
  int                   mismatches, check_count;
  int                   mem[28];

  lscd_top #(.NUM_SEG(28)) lscd_top_inst (.core_clk, .arst_n, .sub_clk_tick, .bus_addr,
    .bus_wr, .bus_wdata, .bus_bit_wr, .bus_bit_idx, .bus_bit_val, .bus_rd, .bus_rdata,
    .seg_port_sel, .seg_level, .seg_drive_en, .com_level);
  lscd_panel_model #(.NUM_SEG(28)) lscd_panel_model_inst (.seg_level, .com_level, .lit);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Strobes drop for a full cycle so back-to-back calls never assign twice in one step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic bwr(input logic [15:0] a, input logic [2:0] i, input logic v);
    bus_addr <= a;
    bus_bit_idx <= i;
    bus_bit_val <= v;
    bus_bit_wr <= 1'b1;
    @(posedge core_clk);
    bus_bit_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    @(posedge core_clk);
    chk($sformatf("rd %h", a), exp, bus_rdata);
  endtask

  task automatic zero();
    for (int s = 0; s < 28; s++) chk($sformatf("seg%0d", s), 0, seg_level[s]);
    for (int c = 0; c < 4; c++) chk($sformatf("com%0d", c), 0, com_level[c]);
  endtask

  // Samples the middle of each slot, so divider start-up phase does not matter
  task automatic scan(input logic [7:0] cv, input int nsl, input int per, input int frames,
                      input logic [7:0] mv);
    int sl;
    int pol;
    int b;
    wr(lscd_pkg::MODE_ADDR, 8'h00);
    wr(lscd_pkg::CLK_ADDR, cv);
    wr(lscd_pkg::MODE_ADDR, mv & 8'h01);
    wr(lscd_pkg::MODE_ADDR, (mv & 8'h01) | 8'h10);
    wr(lscd_pkg::MODE_ADDR, mv);
    repeat (per / 2 - 3) @(posedge core_clk);
    for (int k = 0; k < nsl * frames; k++) begin
      @(negedge core_clk);
      sl = k % nsl;
      pol = (k / nsl) % 2;
      for (int s = 0; s < 28; s++) begin
        b = (mv[7] && ((mem[s] >> sl) & 1)) ? 1 : 0;
        if (s < 16 || !seg_port_sel[s - 16]) begin
          chk($sformatf("seg%0d", s), b ? (pol ? 3 : 0) : (pol ? 1 : 2), seg_level[s]);
          chk($sformatf("lit%0d", s), b, lit[s][sl]);
        end
      end
      for (int c = 0; c < 4; c++)
        chk($sformatf("com%0d", c), (c == sl) ? (pol ? 0 : 3) : (pol ? 2 : 1), com_level[c]);
      repeat (per - 1) @(posedge core_clk);
    end
    @(posedge core_clk);
    $display("test scan clk %h mode %h done", cv, mv);
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    mismatches++;
    test_done();
  end

  initial begin
    mismatches = 0;
    check_count = 0;
    arst_n = 1'b0;
    sub_clk_tick = 1'b1;
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_bit_wr = 1'b0;
    bus_bit_idx = 3'h0;
    bus_bit_val = 1'b0;
    bus_rd = 1'b0;
    void'($urandom(32'hDC99D7A1));
    seg_port_sel = 12'($urandom());
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    zero();
    @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    chk("drive_en", {4'h0, ~seg_port_sel, 16'hFFFF}, seg_drive_en);
    rd(lscd_pkg::MODE_ADDR, 8'h00);
    rd(lscd_pkg::CLK_ADDR, 8'h00);
    wr(lscd_pkg::MODE_ADDR, 8'hFF);
    rd(lscd_pkg::MODE_ADDR, 8'h91);
    wr(lscd_pkg::MODE_ADDR, 8'h00);
    wr(lscd_pkg::CLK_ADDR, 8'hFF);
    rd(lscd_pkg::CLK_ADDR, 8'h0F);
    wr(16'hFFB1, 8'hFF);
    rd(16'hFFB1, 8'h00);
    wr(lscd_pkg::MODE_ADDR, 8'h00);
    bwr(lscd_pkg::MODE_ADDR, 3'h4, 1'b1);
    bwr(lscd_pkg::MODE_ADDR, 3'h0, 1'b1);
    rd(lscd_pkg::MODE_ADDR, 8'h11);
    bwr(lscd_pkg::CLK_ADDR, 3'h3, 1'b0);
    rd(lscd_pkg::CLK_ADDR, 8'h07);
    for (int i = 0; i < 28; i++) begin
      mem[i] = $urandom() & 255;
      wr(lscd_pkg::MEM_BASE + 16'(i), 8'(mem[i]));
      mem[i] = mem[i] & 15;
    end
    bwr(lscd_pkg::MEM_BASE + 16'h0005, 3'h1, ~mem[5][1]);
    mem[5] = mem[5] ^ 2;
    for (int i = 0; i < 28; i++) rd(lscd_pkg::MEM_BASE + 16'(i), 8'(mem[i]));
    $display("test registers done");
    wr(lscd_pkg::MODE_ADDR, 8'h80);
    repeat (70) @(posedge core_clk);
    @(negedge core_clk);
    zero();
    @(posedge core_clk);
    for (int d = 0; d < 4; d++) scan(8'(d), 4, 64 << d, 2, 8'h90);
    scan(8'h00, 3, 64, 2, 8'h91);
    scan(8'h00, 4, 64, 2, 8'h10);
    sub_clk_tick <= 1'b0;
    scan(8'h04, 3, 2048, 2, 8'h91);
    scan(8'h08, 3, 4096, 1, 8'h91);
    scan(8'h0C, 3, 8192, 1, 8'h91);
    test_done();
  end
endmodule
